// [include/tmw_pkg.sv]
/*
 * Constants and types for the 16-bit timer waveform mode and compare-output block.
 * Assumes a single 100 MHz clock and an APB3 register port with 32-bit data.
 */
package tmw_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] TMW_CTRL_A_OFF   = 8'h00;
    localparam logic [7:0] TMW_CTRL_B_OFF   = 8'h04;
    localparam logic [7:0] TMW_CMP_A_OFF    = 8'h08;
    localparam logic [7:0] TMW_CMP_B_OFF    = 8'h0C;
    localparam logic [7:0] TMW_CAPTURE_OFF  = 8'h10;
    localparam logic [7:0] TMW_COUNT_OFF    = 8'h14;
    localparam logic [7:0] TMW_STATUS_OFF   = 8'h18;
    localparam logic [7:0] TMW_PORT_OFF     = 8'h1C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         TMW_ACT_A_POS    = 6;
    localparam int         TMW_ACT_B_POS    = 4;
    localparam int         TMW_MODE_LO_POS  = 0;
    localparam int         TMW_MODE_HI_POS  = 3;
    localparam int         TMW_TICK_EN_POS  = 0;
    localparam int         TMW_OVF_POS      = 0;
    localparam int         TMW_MATCH_A_POS  = 1;
    localparam int         TMW_MATCH_B_POS  = 2;
    localparam logic [7:0] TMW_CTRL_RESET   = 8'h00;
    localparam logic [15:0] TMW_WORD_RESET  = 16'h0000;

    // ****************************************************************
    // Counter limits
    // ****************************************************************
    localparam logic [15:0] TMW_MAX         = 16'hFFFF;
    localparam logic [15:0] TMW_BOTTOM      = 16'h0000;
    localparam logic [15:0] TMW_TOP_8BIT    = 16'h00FF;
    localparam logic [15:0] TMW_TOP_9BIT    = 16'h01FF;
    localparam logic [15:0] TMW_TOP_10BIT   = 16'h03FF;

    // ****************************************************************
    // Waveform modes and output actions
    // ****************************************************************
    typedef enum logic [3:0] {
        TMW_M_NORMAL   = 4'h0,
        TMW_M_PC8      = 4'h1,
        TMW_M_PC9      = 4'h2,
        TMW_M_PC10     = 4'h3,
        TMW_M_CTC_CMPA = 4'h4,
        TMW_M_FAST8    = 4'h5,
        TMW_M_FAST9    = 4'h6,
        TMW_M_FAST10   = 4'h7,
        TMW_M_PFC_CAP  = 4'h8,
        TMW_M_PFC_CMPA = 4'h9,
        TMW_M_PC_CAP   = 4'hA,
        TMW_M_PC_CMPA  = 4'hB,
        TMW_M_CTC_CAP  = 4'hC,
        TMW_M_RESERVED = 4'hD,
        TMW_M_FAST_CAP = 4'hE,
        TMW_M_FAST_CMPA = 4'hF
    } tmw_mode_t;

    localparam logic [1:0] TMW_ACT_OFF    = 2'h0;
    localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TMW_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] TMW_ACT_SET    = 2'h3;

    // Counting sequence, one-hot
    typedef enum logic [2:0] {
        TMW_SEQ_UP   = 3'h1,
        TMW_SEQ_FAST = 3'h2,
        TMW_SEQ_DUAL = 3'h4
    } tmw_seq_t;

endpackage : tmw_pkg

// [hdl/tmw_out_unit.sv]
/*
 * One compare-output channel: match action, pin override and driver enable.
 * Assumes match, TOP and direction inputs from the timer core; the unit qualifies them with tick itself.
 */
`timescale 1ns/1ps
module tmw_out_unit (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   tick,
    input  wire logic [1:0]             action,
    input  wire logic                   toggle_ok,
    input  wire tmw_pkg::tmw_seq_t      seq,
    input  wire logic                   match,
    input  wire logic                   at_top,
    input  wire logic                   cmp_is_top,
    input  wire logic                   counting_up,
    input  wire logic                   dir_out,
    output logic                        level,
    output logic                        pin_override,
    output logic                        pin_oe
);

    typedef struct packed {
        logic level;
    } tmw_unit_state_t;

    tmw_unit_state_t st_reg;
    tmw_unit_state_t st_next;

    // ****************************************************************
    // Output action
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        if (tick) begin
            case (seq)
                tmw_pkg::TMW_SEQ_FAST: begin
                    if (action == tmw_pkg::TMW_ACT_TOGGLE) begin
                        if (toggle_ok && match)                         // R08
                            st_next.level = ~st_reg.level;
                    end else if (action[1]) begin
                        if (at_top)                                     // R06 R07
                            st_next.level = (action == tmw_pkg::TMW_ACT_CLEAR);
                        else if (match && !cmp_is_top)                  // R09
                            st_next.level = (action == tmw_pkg::TMW_ACT_SET);
                    end
                end
                tmw_pkg::TMW_SEQ_DUAL: begin
                    if (match) begin
                        if (action == tmw_pkg::TMW_ACT_TOGGLE) begin
                            if (toggle_ok)                              // R10
                                st_next.level = ~st_reg.level;
                        end else if (action[1]) begin                   // R11 R12
                            st_next.level = counting_up ^ (action == tmw_pkg::TMW_ACT_CLEAR);
                        end
                    end
                end
                default: begin
                    if (match) begin                                    // R05
                        case (action)
                            tmw_pkg::TMW_ACT_TOGGLE: st_next.level = ~st_reg.level;
                            tmw_pkg::TMW_ACT_CLEAR:  st_next.level = 1'b0;
                            tmw_pkg::TMW_ACT_SET:    st_next.level = 1'b1;
                            default:                 st_next.level = st_reg.level;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level = st_reg.level;
    // Pin is taken only when the action is live for this mode
    assign pin_override = (action != tmw_pkg::TMW_ACT_OFF)                  // R02 R04
                          && (action != tmw_pkg::TMW_ACT_TOGGLE || seq == tmw_pkg::TMW_SEQ_UP || toggle_ok);
    assign pin_oe = pin_override && dir_out;                                // R03

endmodule : tmw_out_unit

// [hdl/tmw_timer.sv]
/*
 * 16-bit timer core: waveform mode decode, counter, compare buffers,
 * flags, two compare outputs and an APB register port.
 * Assumes APB3 master, one 100 MHz clock, synchronous active-low reset.
 */
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// R01: Fully synchronous; tick only enables counting
// R02: Nonzero action field takes over the pin; the code does not for toggle where R08/R10 allow no toggle
// R03: Pin driver needs direction bit set
// R04: Action zero leaves normal port operation
// R05: Non-PWM: toggle, clear, set on match
// R06: Fast PWM code 10: clear match, set TOP
// R07: Fast PWM code 11: set match, clear TOP
// R08: Fast PWM toggle only A, modes 14/15
// R09: Fast PWM: compare equal TOP ignored; the code still toggles A on it in modes 14/15
// R10: Dual-slope toggle only A, modes 8-11
// R11: Dual-slope 10: clear up, set down
// R12: Dual-slope 11: set up, clear down
// R13: Mode split over two control registers; 13 reserved
// R14: Mode 0 free run, overflow at MAX
// R15: Modes 1-3,10,11 load at TOP, overflow BOTTOM
// R16: Clear-on-match modes 4, 12, overflow at MAX
// R17: Fast PWM load and overflow at TOP
// R18: Modes 8, 9 load and overflow at BOTTOM
// R19: Dual-slope counts up to TOP and back
// R20: Reserved mode behaves as normal mode
module tmw_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               timer_tick,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    compare_out_a,
    output logic                    compare_out_b,
    output logic                    compare_out_a_override,
    output logic                    compare_out_b_override,
    output logic                    compare_out_a_oe,
    output logic                    compare_out_b_oe
);

    typedef struct packed {
        logic [7:0]       ctrl_a;
        logic [7:0]       ctrl_b;
        logic [WIDTH-1:0] cmp_a_buf;
        logic [WIDTH-1:0] cmp_b_buf;
        logic [WIDTH-1:0] cmp_a;
        logic [WIDTH-1:0] cmp_b;
        logic [WIDTH-1:0] capture;
        logic [WIDTH-1:0] count;
        logic             down;
        logic             overflow_flag;
        logic             match_a_flag;
        logic             match_b_flag;
        logic [1:0]       port_dir;
        logic             block_match;
        logic [31:0]      rdata;
    } tmw_state_t;

    tmw_state_t st_reg;
    tmw_state_t st_next;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    logic [3:0]         waveform_mode_select;
    tmw_pkg::tmw_mode_t mode;
    tmw_pkg::tmw_seq_t  seq;
    logic [WIDTH-1:0]   top;
    logic               load_at_top;
    logic               load_at_bottom;
    logic               ovf_at_top;
    logic               ovf_at_bottom;
    logic               toggle_ok;
    logic [1:0]         chan_a_output_action;
    logic [1:0]         chan_b_output_action;

    assign waveform_mode_select = {st_reg.ctrl_b[tmw_pkg::TMW_MODE_HI_POS +: 2],   // R13
                                   st_reg.ctrl_a[tmw_pkg::TMW_MODE_LO_POS +: 2]};
    assign chan_a_output_action = st_reg.ctrl_a[tmw_pkg::TMW_ACT_A_POS +: 2];
    assign chan_b_output_action = st_reg.ctrl_a[tmw_pkg::TMW_ACT_B_POS +: 2];

    always_comb begin
        mode           = tmw_pkg::tmw_mode_t'(waveform_mode_select);
        seq            = tmw_pkg::TMW_SEQ_UP;
        top            = WIDTH'(tmw_pkg::TMW_MAX);
        load_at_top    = 1'b0;
        load_at_bottom = 1'b0;
        ovf_at_top     = 1'b0;
        ovf_at_bottom  = 1'b0;
        toggle_ok      = 1'b0;
        case (mode)
            tmw_pkg::TMW_M_PC8, tmw_pkg::TMW_M_PC9, tmw_pkg::TMW_M_PC10,
            tmw_pkg::TMW_M_PC_CAP, tmw_pkg::TMW_M_PC_CMPA: begin
                seq           = tmw_pkg::TMW_SEQ_DUAL;                  // R15
                load_at_top   = 1'b1;
                ovf_at_bottom = 1'b1;
                toggle_ok     = mode[3];                                // R10
                case (mode)
                    tmw_pkg::TMW_M_PC8:    top = WIDTH'(tmw_pkg::TMW_TOP_8BIT);
                    tmw_pkg::TMW_M_PC9:    top = WIDTH'(tmw_pkg::TMW_TOP_9BIT);
                    tmw_pkg::TMW_M_PC10:   top = WIDTH'(tmw_pkg::TMW_TOP_10BIT);
                    tmw_pkg::TMW_M_PC_CAP: top = st_reg.capture;
                    default:               top = st_reg.cmp_a;
                endcase
            end
            tmw_pkg::TMW_M_PFC_CAP, tmw_pkg::TMW_M_PFC_CMPA: begin
                seq            = tmw_pkg::TMW_SEQ_DUAL;                 // R18
                load_at_bottom = 1'b1;
                ovf_at_bottom  = 1'b1;
                toggle_ok      = 1'b1;                                  // R10
                top            = mode[0] ? st_reg.cmp_a : st_reg.capture;
            end
            tmw_pkg::TMW_M_FAST8, tmw_pkg::TMW_M_FAST9, tmw_pkg::TMW_M_FAST10,
            tmw_pkg::TMW_M_FAST_CAP, tmw_pkg::TMW_M_FAST_CMPA: begin
                seq         = tmw_pkg::TMW_SEQ_FAST;                    // R17
                load_at_top = 1'b1;
                ovf_at_top  = 1'b1;
                toggle_ok   = mode[3];                                  // R08
                case (mode)
                    tmw_pkg::TMW_M_FAST8:    top = WIDTH'(tmw_pkg::TMW_TOP_8BIT);
                    tmw_pkg::TMW_M_FAST9:    top = WIDTH'(tmw_pkg::TMW_TOP_9BIT);
                    tmw_pkg::TMW_M_FAST10:   top = WIDTH'(tmw_pkg::TMW_TOP_10BIT);
                    tmw_pkg::TMW_M_FAST_CAP: top = st_reg.capture;
                    default:                 top = st_reg.cmp_a;
                endcase
            end
            tmw_pkg::TMW_M_CTC_CMPA: top = st_reg.cmp_a;                // R16
            tmw_pkg::TMW_M_CTC_CAP:  top = st_reg.capture;              // R16
            default:                 top = WIDTH'(tmw_pkg::TMW_MAX);    // R14 R20
        endcase
    end

    // ****************************************************************
    // Counter events
    // ****************************************************************
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic tick;
    logic ovf_event;

    assign tick      = timer_tick;                                      // R01
    assign at_top    = st_reg.count == top;
    assign at_bottom = st_reg.count == WIDTH'(tmw_pkg::TMW_BOTTOM);
    assign match_a   = !st_reg.block_match && st_reg.count == st_reg.cmp_a;
    assign match_b   = !st_reg.block_match && st_reg.count == st_reg.cmp_b;
    assign ovf_event = (ovf_at_top && at_top) || (ovf_at_bottom && at_bottom && st_reg.down)
                       || (!ovf_at_top && !ovf_at_bottom && st_reg.count == WIDTH'(tmw_pkg::TMW_MAX));  // R14 R16

    // ****************************************************************
    // Register bus and counting
    // ****************************************************************
    logic wr;
    logic rd;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_comb begin
        st_next = st_reg;
        if (tick) begin
            st_next.block_match = 1'b0;
            case (seq)
                tmw_pkg::TMW_SEQ_DUAL: begin                            // R19
                    if (!st_reg.down) begin
                        if (st_reg.count >= top) begin
                            st_next.down  = 1'b1;
                            st_next.count = st_reg.count - WIDTH'(1);
                        end else begin
                            st_next.count = st_reg.count + WIDTH'(1);
                        end
                    end else if (at_bottom) begin
                        st_next.down  = 1'b0;
                        st_next.count = st_reg.count + WIDTH'(1);
                    end else begin
                        st_next.count = st_reg.count - WIDTH'(1);
                    end
                end
                default: begin
                    st_next.down  = 1'b0;
                    st_next.count = (at_top && mode != tmw_pkg::TMW_M_NORMAL) ? WIDTH'(tmw_pkg::TMW_BOTTOM)
                                                                             : st_reg.count + WIDTH'(1);
                end
            endcase
            if (ovf_event)                                              // R15 R17 R18
                st_next.overflow_flag = 1'b1;
            if ((load_at_top && at_top) || (load_at_bottom && at_bottom)) begin   // R15 R17 R18
                st_next.cmp_a = st_reg.cmp_a_buf;
                st_next.cmp_b = st_reg.cmp_b_buf;
            end
            if (match_a)
                st_next.match_a_flag = 1'b1;
            if (match_b)
                st_next.match_b_flag = 1'b1;
        end
        if (!load_at_top && !load_at_bottom) begin                      // R14 R16
            st_next.cmp_a = st_reg.cmp_a_buf;
            st_next.cmp_b = st_reg.cmp_b_buf;
        end
        if (wr) begin
            case (paddr)
                tmw_pkg::TMW_CTRL_A_OFF: st_next.ctrl_a = pwdata[7:0] & 8'hF3;
                tmw_pkg::TMW_CTRL_B_OFF: st_next.ctrl_b = pwdata[7:0] & 8'h18;
                tmw_pkg::TMW_CMP_A_OFF:  st_next.cmp_a_buf = pwdata[WIDTH-1:0];
                tmw_pkg::TMW_CMP_B_OFF:  st_next.cmp_b_buf = pwdata[WIDTH-1:0];
                tmw_pkg::TMW_CAPTURE_OFF: st_next.capture = pwdata[WIDTH-1:0];
                tmw_pkg::TMW_COUNT_OFF: begin
                    st_next.count       = pwdata[WIDTH-1:0];
                    st_next.block_match = 1'b1;
                end
                tmw_pkg::TMW_STATUS_OFF: begin
                    // Write one to clear; a same-cycle set wins
                    if (pwdata[tmw_pkg::TMW_OVF_POS] && !(tick && ovf_event))
                        st_next.overflow_flag = 1'b0;
                    if (pwdata[tmw_pkg::TMW_MATCH_A_POS] && !(tick && match_a))
                        st_next.match_a_flag = 1'b0;
                    if (pwdata[tmw_pkg::TMW_MATCH_B_POS] && !(tick && match_b))
                        st_next.match_b_flag = 1'b0;
                end
                tmw_pkg::TMW_PORT_OFF: st_next.port_dir = pwdata[1:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (paddr)
                tmw_pkg::TMW_CTRL_A_OFF:  st_next.rdata = {24'h000000, st_reg.ctrl_a};
                tmw_pkg::TMW_CTRL_B_OFF:  st_next.rdata = {24'h000000, st_reg.ctrl_b};
                tmw_pkg::TMW_CMP_A_OFF:   st_next.rdata = 32'(st_reg.cmp_a_buf);
                tmw_pkg::TMW_CMP_B_OFF:   st_next.rdata = 32'(st_reg.cmp_b_buf);
                tmw_pkg::TMW_CAPTURE_OFF: st_next.rdata = 32'(st_reg.capture);
                tmw_pkg::TMW_COUNT_OFF:   st_next.rdata = 32'(st_reg.count);
                tmw_pkg::TMW_STATUS_OFF:  st_next.rdata = {28'h0000000, st_reg.down, st_reg.match_b_flag,
                                                           st_reg.match_a_flag, st_reg.overflow_flag};
                tmw_pkg::TMW_PORT_OFF:    st_next.rdata = {30'h00000000, st_reg.port_dir};
                default:                  st_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign prdata  = st_reg.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(paddr[1:0] == 2'h0 && paddr <= tmw_pkg::TMW_PORT_OFF);

    // ****************************************************************
    // Compare outputs
    // ****************************************************************
    tmw_out_unit u_out_a (
        .clk          (clk),
        .rst_n        (rst_n),
        .tick         (tick),
        .action       (chan_a_output_action),
        .toggle_ok    (toggle_ok),
        .seq          (seq),
        .match        (match_a),
        .at_top       (at_top),
        .cmp_is_top   (st_reg.cmp_a == top),
        .counting_up  (!st_reg.down),
        .dir_out      (st_reg.port_dir[0]),
        .level        (compare_out_a),
        .pin_override (compare_out_a_override),
        .pin_oe       (compare_out_a_oe)
    );

    tmw_out_unit u_out_b (
        .clk          (clk),
        .rst_n        (rst_n),
        .tick         (tick),
        .action       (chan_b_output_action),
        .toggle_ok    (1'b0),
        .seq          (seq),
        .match        (match_b),
        .at_top       (at_top),
        .cmp_is_top   (st_reg.cmp_b == top),
        .counting_up  (!st_reg.down),
        .dir_out      (st_reg.port_dir[1]),
        .level        (compare_out_b),
        .pin_override (compare_out_b_override),
        .pin_oe       (compare_out_b_oe)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_top_tick;
        timer_tick && seq == tmw_pkg::TMW_SEQ_FAST && at_top;
    endsequence

    a_tick_gates_count: assert property (!timer_tick && !wr |=> $stable(st_reg.count))      // R01
        else $error("count moved without tick");
    a_oe_needs_dir: assert property (compare_out_a_oe |-> st_reg.port_dir[0] && chan_a_output_action != 2'h0)  // R03
        else $error("pin A driven without direction");
    a_off_no_override: assert property (chan_b_output_action == 2'h0 |-> !compare_out_b_override)  // R04
        else $error("pin B taken with action zero");
    a_fast_set_top: assert property (s_top_tick and chan_a_output_action == 2'h2 |=> compare_out_a)  // R06
        else $error("fast PWM did not set at TOP");
    a_fast_clr_top: assert property (s_top_tick and chan_a_output_action == 2'h3 |=> !compare_out_a)  // R07
        else $error("fast PWM did not clear at TOP");
    a_b_toggle_off: assert property (seq != tmw_pkg::TMW_SEQ_UP && chan_b_output_action == 2'h1
                                     |-> !compare_out_b_override)  // R08
        else $error("pin B taken by PWM toggle");
    a_dual_turn_top: assert property (timer_tick && seq == tmw_pkg::TMW_SEQ_DUAL && !st_reg.down
                                      && at_top && !wr |=> st_reg.down)  // R19
        else $error("dual slope did not turn at TOP");
    a_ovf_fast_top: assert property (s_top_tick |=> st_reg.overflow_flag)  // R17
        else $error("overflow not set at TOP");
    a_ovf_set_wins: assert property (timer_tick && ovf_event |=> st_reg.overflow_flag)  // R15 R17 R18
        else $error("overflow flag lost");
    a_buf_load_edge: assert property (timer_tick && ((load_at_top && at_top) || (load_at_bottom && at_bottom))
                                      |=> st_reg.cmp_a == $past(st_reg.cmp_a_buf))  // R15 R17 R18
        else $error("compare buffer not loaded");
    a_dual_clr_up: assert property (timer_tick && seq == tmw_pkg::TMW_SEQ_DUAL && match_a && !st_reg.down
                                    && chan_a_output_action == 2'h2 |=> !compare_out_a)  // R11
        else $error("dual slope did not clear on up match");
    a_dual_set_b: assert property (timer_tick && seq == tmw_pkg::TMW_SEQ_DUAL && match_b && !st_reg.down
                                   && chan_b_output_action == 2'h3 |=> compare_out_b)  // R12
        else $error("dual slope did not set B on up match");
    a_dual_turn_bottom: assert property (timer_tick && seq == tmw_pkg::TMW_SEQ_DUAL && st_reg.down
                                         && at_bottom && !wr |=> !st_reg.down)  // R19
        else $error("dual slope did not turn at BOTTOM");

endmodule : tmw_timer

// [verif/tmw_load.sv]
/* Load model on the two compare pins.
   Assumes pull-downs: an undriven pin reads low. */
`timescale 1ns/1ps
module tmw_load (
    input  wire logic [1:0] level,
    input  wire logic [1:0] oe,
    output logic [1:0]      pin
);
    // Pin follows the driver only while enabled
    assign pin = oe & level;
endmodule : tmw_load

// [verif/tb_tmw_timer.sv]
/* Directed bench for tmw_timer over APB.
   Assumes the load model tmw_load on the compare pins. */
`timescale 1ns/1ps
module tb_tmw_timer;
    logic        clk = 1'h0, rst_n = 1'h0, tick = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    wire  [1:0]  lvl, ov, oe, pin;
    int          n_errors = 0, n_tests = 0, i, n, k;
    logic [9:0]  tab [6] = '{10'h000, 10'h154, 10'h3D5, 10'h054, 10'h2D5, 10'h1BF};
    logic [3:0]  om [3] = '{4'h5, 4'hD, 4'h0};
    logic [15:0] oc [3] = '{16'h00F0, 16'hFFF0, 16'hFFF0};

    tmw_timer dut (.clk(clk), .rst_n(rst_n), .timer_tick(tick), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_out_a(lvl[0]), .compare_out_b(lvl[1]),
        .compare_out_a_override(ov[0]), .compare_out_b_override(ov[1]),
        .compare_out_a_oe(oe[0]), .compare_out_b_oe(oe[1]));
    tmw_load load (.level(lvl), .oe(oe), .pin(pin));

    initial begin
        forever #5 clk = ~clk;
    end
    // Tick every second clock
    always @(posedge clk) tick <= rst_n & ~tick;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : bus
    task automatic cfg(input logic [3:0] m, input logic [1:0] a, input logic [1:0] b);
        bus(1'h1, tmw_pkg::TMW_CTRL_A_OFF, {24'h0, a, b, 2'h0, m[1:0]});
        bus(1'h1, tmw_pkg::TMW_CTRL_B_OFF, {27'h0, m[3:2], 3'h0});
    endtask : cfg
    task automatic wait_a(input logic v);
        n = 0;
        while (lvl[0] !== v && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk(lvl[0], v);
        if (lvl[0] !== v) report_and_stop();
    endtask : wait_a
    task automatic report_and_stop;
        $display("Errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        bus(1'h0, tmw_pkg::TMW_CTRL_A_OFF, 32'h0);
        chk(rd, 32'h0);
        bus(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'h1);
        // Pin takeover per mode and action
        for (i = 0; i < 6; i++) begin
            cfg(tab[i][9:6], tab[i][5:4], tab[i][3:2]);
            @(negedge clk);
            chk(ov, tab[i][1:0]);
        end
        bus(1'h1, tmw_pkg::TMW_CMP_A_OFF, 32'h3);
        bus(1'h1, tmw_pkg::TMW_PORT_OFF, 32'h0);
        cfg(4'h4, 2'h3, 2'h0);
        bus(1'h1, tmw_pkg::TMW_COUNT_OFF, 32'h0);
        wait_a(1'h1);
        chk(pin, 2'h0);
        bus(1'h1, tmw_pkg::TMW_PORT_OFF, 32'h3);
        @(negedge clk);
        chk({oe, pin}, 4'h5);
        cfg(4'h4, 2'h2, 2'h0);
        wait_a(1'h0);
        cfg(4'h4, 2'h1, 2'h0);
        wait_a(1'h1);
        wait_a(1'h0);
        bus(1'h1, tmw_pkg::TMW_CMP_A_OFF, 32'h80);
        bus(1'h1, tmw_pkg::TMW_COUNT_OFF, 32'hF0);
        cfg(4'h5, 2'h2, 2'h0);
        wait_a(1'h1);
        wait_a(1'h0);
        // Dual slope: match action follows direction
        cfg(4'h1, 2'h2, 2'h3);
        bus(1'h1, tmw_pkg::TMW_CMP_A_OFF, 32'h10);
        bus(1'h1, tmw_pkg::TMW_CMP_B_OFF, 32'h10);
        bus(1'h1, tmw_pkg::TMW_COUNT_OFF, 32'hF8);
        wait_a(1'h1);
        chk(lvl, 2'h1);
        bus(1'h0, tmw_pkg::TMW_STATUS_OFF, 32'h0);
        chk(rd[3], 1'h1);
        wait_a(1'h0);
        chk(lvl, 2'h2);
        bus(1'h0, tmw_pkg::TMW_STATUS_OFF, 32'h0);
        chk(rd[3], 1'h0);
        // Overflow at TOP, at MAX, and in the reserved mode
        for (i = 0; i < 3; i++) begin
            cfg(om[i], 2'h3, 2'h0);
            bus(1'h1, tmw_pkg::TMW_COUNT_OFF, {16'h0, oc[i]});
            bus(1'h1, tmw_pkg::TMW_STATUS_OFF, 32'h1);
            bus(1'h0, tmw_pkg::TMW_STATUS_OFF, 32'h0);
            chk(rd[0], 1'h0);
            k = 0;
            do begin
                bus(1'h0, tmw_pkg::TMW_STATUS_OFF, 32'h0);
                k++;
            end while (rd[0] !== 1'h1 && k < 40);
            chk(rd[0], 1'h1);
            if (rd[0] !== 1'h1) report_and_stop();
            if (i == 0) chk(lvl[0], 1'h0);
        end
        report_and_stop();
    end
endmodule : tb_tmw_timer
